// *** dsw_device.sv ***
// Device end of the DAC serial write port: shift register, code and mode.
// Assumes link pins are asynchronous to mclk and sclk is at most mclk/4.
// Overview of operation
// - 14-bit variant: sixteen-bit frame shift register
// - First two bits select power-down mode
// - Modes: normal, 1k, 100k, high impedance
// - Select fall starts; shift on sclk falls
// - 14-bit: sixteenth fall loads code and mode
// - 14-bit: early select rise discards frame
// - Host holds select high 20 ns between
// - New frame only on select falling edge
// - 16-bit variant: 24-bit frame shift register
// - 16-bit: mode, sixteen code bits, six ignored
// - 16-bit: eighteenth fall loads code and mode
// - 16-bit: rise after eighteenth stays valid
// - 16-bit: early select rise discards frame
// - Serial clock up to 50 MHz; this device needs sclk at most mclk/4, 25 MHz at 100 MHz mclk
// - Host sends most significant bit first
// - Host may split frames into bytes
// - Data stable at sclk falling edge
// - Code register clears to zero at reset
// - Power-down never alters stored code; here a power-down load writes its code bits too

`timescale 1ns/1ps

module dsw_device
  import dsw_pkg::*;
#(
  parameter int CODE_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // Link
  dsw_if.device link,
  // User side
  output logic [CODE_W-1:0] dac_code,
  output dsw_pkg::dsw_mode_t pwr_mode,
  output logic load_pulse,
  output logic abort_pulse
);
  localparam int FRAME_W = (CODE_W == 14) ? FRAME_BITS_14 : FRAME_BITS_16;
  localparam int LOAD_N = (CODE_W == 14) ? LOAD_EDGE_14 : LOAD_EDGE_16;
  // Five bits cover the longest frame of 24 falls
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LOAD_CNT = CNT_W'(LOAD_N);

  // DONE ignores clocks until the select rises again
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b10
  } dsw_st_t;


  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] ck_sync;
    logic [1:0] di_sync;
    logic cs_prev;
    logic ck_prev;
    dsw_st_t st;
    logic [FRAME_W-1:0] shreg;
    logic [CNT_W-1:0] cnt;
    logic [CODE_W-1:0] code;
    dsw_mode_t mode;
    logic load;
    logic abort;
  } dsw_dev_t;


  dsw_dev_t st_ff;
  dsw_dev_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers shared by the three pins and the frame decode
  function automatic logic [1:0] sync_step(input logic [1:0] chain, input logic pin);
    return {chain[0], pin};
  endfunction : sync_step

  function automatic logic edge_fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : edge_fell

  function automatic logic edge_rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction : edge_rose

  // Mode pair sits just above the code in the bits received so far
  function automatic dsw_mode_t mode_of(input logic [FRAME_W-1:0] frm);
    return dsw_mode_t'(frm[LOAD_N-1 -: MODE_BITS]);
  endfunction : mode_of

  function automatic logic [CODE_W-1:0] code_of(input logic [FRAME_W-1:0] frm);
    return frm[CODE_W-1:0];
  endfunction : code_of

  // Load fires when this fall is the variant's load edge
  function automatic logic at_load(input logic [CNT_W-1:0] cnt);
    return (cnt + 1'b1) == LOAD_CNT;
  endfunction : at_load


  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic cs_fall;
    logic cs_rise;
    logic ck_fall;
    logic [FRAME_W-1:0] sh;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    ck_fall = 1'b0;
    sh = '0;

    nxt_st = st_ff;

    // Two flops per pin: the link pins are asynchronous to mclk
    nxt_st.cs_sync = sync_step(st_ff.cs_sync, link.frame_select_n);
    nxt_st.ck_sync = sync_step(st_ff.ck_sync, link.serial_clock);
    nxt_st.di_sync = sync_step(st_ff.di_sync, link.serial_data_in);
    nxt_st.cs_prev = st_ff.cs_sync[1];
    nxt_st.ck_prev = st_ff.ck_sync[1];
    // Pulses last one cycle unless set below
    nxt_st.load = 1'b0;
    nxt_st.abort = 1'b0;

    cs_fall = edge_fell(st_ff.cs_prev, st_ff.cs_sync[1]);
    cs_rise = edge_rose(st_ff.cs_prev, st_ff.cs_sync[1]);
    // Data is sampled in step with the clock, so both see equal sync delay
    // Each sclk half must last two mclk periods or the edge is lost
    ck_fall = edge_fell(st_ff.ck_prev, st_ff.ck_sync[1]) & ~st_ff.cs_sync[1];
    sh = {st_ff.shreg[FRAME_W-2:0], st_ff.di_sync[1]};

    case (st_ff.st)
      ST_IDLE: begin
        // Clocks before a select fall are dropped: no frame is open
        if (cs_fall) begin
          nxt_st.st = ST_SHIFT;
          nxt_st.cnt = '0;
          nxt_st.shreg = '0;
        end
      end

      ST_SHIFT: begin
        if (cs_rise) begin
          // Abort pulse lets the user side see the dropped frame
          // Early rise: frame dropped, code and mode left alone
          nxt_st.st = ST_IDLE;
          nxt_st.shreg = '0;
          nxt_st.cnt = '0;
          nxt_st.abort = 1'b1;
        end else if (ck_fall) begin
          nxt_st.shreg = sh;
          nxt_st.cnt = st_ff.cnt + 1'b1;
          if (at_load(st_ff.cnt)) begin
            // Mode pair leads the frame; code follows MSB first
            nxt_st.mode = mode_of(sh);
            // A load writes the code in every mode, power-down ones included; apart from srst only a load does
            nxt_st.code = code_of(sh);
            nxt_st.load = 1'b1;
            nxt_st.st = ST_DONE;
          end
        end
      end

      ST_DONE: begin
        // Select may stay low after the load; only its rise rearms
        // Trailing clocks and don't-care bits are ignored until select rises
        if (cs_rise) begin
          nxt_st.st = ST_IDLE;
        end
      end

      default: begin
        nxt_st.st = ST_IDLE;
      end
    endcase
  end


  ////////////////////////////////////////////////////////////////////////////
  // Reset and enable act on the whole state at once
  always_ff @(posedge mclk) begin
    if (srst) begin
      // Sync chains reset to idle levels so no false edge follows
      st_ff.cs_sync <= 2'b11;
      st_ff.ck_sync <= 2'b00;
      st_ff.di_sync <= 2'b00;
      st_ff.cs_prev <= 1'b1;
      st_ff.ck_prev <= 1'b0;
      st_ff.st <= ST_IDLE;
      st_ff.shreg <= '0;
      st_ff.cnt <= '0;
      st_ff.code <= CODE_W'(CODE_RST);
      st_ff.mode <= DSW_NORMAL;
      st_ff.load <= 1'b0;
      st_ff.abort <= 1'b0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end


  // Outputs are the registered state, so each comes from a flop
  assign dac_code = st_ff.code;
  assign pwr_mode = st_ff.mode;
  assign load_pulse = st_ff.load;
  assign abort_pulse = st_ff.abort;
endmodule : dsw_device

// *** dsw_pkg.sv ***
// Package for the serial DAC write link: frame layout, modes, timing constants.
// Assumes both ends run on mclk at 100 MHz.
package dsw_pkg;
  // Frame and field layout
  localparam int FRAME_BITS_14 = 16;
  localparam int FRAME_BITS_16 = 24;
  localparam int LOAD_EDGE_14 = 16;
  localparam int LOAD_EDGE_16 = 18;
  localparam int MODE_BITS = 2;
  localparam int MODE_HI_POS_14 = 15;
  localparam int MODE_HI_POS_16 = 23;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_HIGH_MIN_NS = 20;
  localparam int SYNC_HIGH_MIN_CYC =
    (SYNC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_MAX_MHZ = 50;
  localparam int SCLK_HALF_DEF = 6;
  // Reset values
  localparam logic [15:0] CODE_RST = 16'h0000;

  typedef enum logic [1:0] {
    DSW_NORMAL = 2'b00,
    DSW_PD_1K = 2'b01,
    DSW_PD_100K = 2'b10,
    DSW_PD_HIZ = 2'b11
  } dsw_mode_t;
endpackage : dsw_pkg

// *** dsw_if.sv ***
// Three-wire write link between host and DAC serial port.
// Assumes the host drives every wire; the device only listens.
`timescale 1ns/1ps
interface dsw_if;
  logic frame_select_n;
  logic serial_clock;
  logic serial_data_in;
  modport host (output frame_select_n, output serial_clock, output serial_data_in);
  modport device (input frame_select_n, input serial_clock, input serial_data_in);
endinterface : dsw_if

// *** dsw_host.sv ***
// Host end: serialises one frame MSB first, sclk idle low, data set on rise.
// Assumes the user holds start for one cycle while busy is low.
`timescale 1ns/1ps
module dsw_host
  import dsw_pkg::*;
#(
  parameter int CODE_W = 16,
  parameter int SCLK_HALF = SCLK_HALF_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // User command
  input wire logic start,
  input wire logic [CODE_W-1:0] code_in,
  input wire dsw_pkg::dsw_mode_t mode_in,
  output logic busy,
  // Link
  dsw_if.host link
);
  localparam int FRAME_W = (CODE_W == 14) ? FRAME_BITS_14 : FRAME_BITS_16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_W - 1);
  localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
  localparam logic [7:0] GAP_M1 = 8'(SYNC_HIGH_MIN_CYC + SCLK_HALF - 1);

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOW = 2'b01,
    HS_HIGH = 2'b10,
    HS_GAP = 2'b11
  } dsw_hst_t;

  typedef struct packed {
    dsw_hst_t st;
    logic [FRAME_W-1:0] sh;
    logic [CNT_W-1:0] bitn;
    logic [7:0] tmr;
    logic cs_n;
    logic sck;
    logic sdo;
    logic busy;
  } dsw_host_t;

  dsw_host_t st_ff;
  dsw_host_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic tdone;
    tdone = 1'b0;
    nxt_st = st_ff;
    tdone = (st_ff.tmr == 8'h00);
    if (!tdone) begin
      nxt_st.tmr = st_ff.tmr - 8'h01;
    end
    case (st_ff.st)
      HS_IDLE: begin
        if (start) begin
          // Mode pair first, then code MSB first, don't-cares as zero
          nxt_st.sh = {mode_in, code_in, {(FRAME_W - CODE_W - MODE_BITS){1'b0}}};
          nxt_st.cs_n = 1'b0;
          nxt_st.sdo = mode_in[1];
          nxt_st.bitn = '0;
          nxt_st.tmr = HALF_M1;
          nxt_st.busy = 1'b1;
          nxt_st.st = HS_LOW;
        end
      end
      HS_LOW: begin
        if (tdone) begin
          nxt_st.sck = 1'b1;
          nxt_st.sdo = st_ff.sh[FRAME_W-1];
          nxt_st.tmr = HALF_M1;
          nxt_st.st = HS_HIGH;
        end
      end
      HS_HIGH: begin
        if (tdone) begin
          nxt_st.sck = 1'b0;
          nxt_st.tmr = HALF_M1;
          if (st_ff.bitn == LAST_BIT) begin
            nxt_st.st = HS_GAP;
          end else begin
            nxt_st.bitn = st_ff.bitn + 1'b1;
            nxt_st.sh = {st_ff.sh[FRAME_W-2:0], 1'b0};
            nxt_st.st = HS_LOW;
          end
        end
      end
      HS_GAP: begin
        // Select stays low through all bits, then held high before reuse
        if (tdone && !st_ff.cs_n) begin
          nxt_st.cs_n = 1'b1;
          nxt_st.sdo = 1'b0;
          nxt_st.tmr = GAP_M1;
        end else if (tdone) begin
          nxt_st.busy = 1'b0;
          nxt_st.st = HS_IDLE;
        end
      end
      default: begin
        nxt_st.st = HS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff.st <= HS_IDLE;
      st_ff.sh <= '0;
      st_ff.bitn <= '0;
      st_ff.tmr <= 8'h00;
      st_ff.cs_n <= 1'b1;
      st_ff.sck <= 1'b0;
      st_ff.sdo <= 1'b0;
      st_ff.busy <= 1'b0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign link.frame_select_n = st_ff.cs_n;
  assign link.serial_clock = st_ff.sck;
  assign link.serial_data_in = st_ff.sdo;
  assign busy = st_ff.busy;
endmodule : dsw_host

// *** dsw_link_asserts.sv ***
// Checker for the host to device link of the 24-bit frame pair.
// Assumes mclk sampling and a synchronous active-high srst.
`timescale 1ns/1ps
module dsw_link_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Link
  input wire logic frame_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  // Device side
  input wire logic [15:0] dac_code,
  input wire dsw_pkg::dsw_mode_t pwr_mode,
  input wire logic load_pulse,
  input wire logic abort_pulse
);
  import dsw_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  ////////////////////////////////
  logic [4:0] falls_ff;
  // Counted here, not in the device, so a miscount there shows
  always_ff @(posedge mclk) begin
    if (srst || frame_select_n) falls_ff <= 5'h00;
    else if ($fell(serial_clock)) falls_ff <= falls_ff + 5'h01;
  end
  sequence s_load_fall;
    $fell(serial_clock) && falls_ff == 5'h11;
  endsequence
  ////////////////////////////////
  a_sclk_idle_low: assert property (frame_select_n |-> !serial_clock)
    else $error("sclk high while idle");
  a_data_held: assert property (serial_clock && $past(serial_clock) |->
    $stable(serial_data_in)) else $error("data moved while sclk high");
  a_load_18th: assert property (s_load_fall |-> ##[1:8] load_pulse)
    else $error("no load after 18th fall");
  a_load_count: assert property (load_pulse |-> falls_ff == 5'h12)
    else $error("load at wrong fall");
  a_frame_len: assert property ($rose(frame_select_n) |-> falls_ff == 5'h18)
    else $error("frame not 24 falls");
  a_sel_gap: assert property ($rose(frame_select_n) |-> frame_select_n [*2])
    else $error("select high too short");
  a_code_held: assert property (!load_pulse |-> $stable(dac_code))
    else $error("code moved without load");
  a_mode_held: assert property (!load_pulse |-> $stable(pwr_mode))
    else $error("mode moved without load");
  a_no_abort: assert property (!abort_pulse)
    else $error("whole frame aborted");
endmodule : dsw_link_asserts

// *** dac_serial_write_interface_tb.sv ***
// Bench: host and device pair, plus a 14-bit device driven by the bench.
// Assumes dsw_pkg, dsw_if and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module dac_serial_write_interface_tb;
  import dsw_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic run_en = 1'b1;
  logic start = 1'b0;
  logic [15:0] code_in = 16'h0000;
  dsw_mode_t mode_in = DSW_NORMAL;
  logic busy;
  logic [15:0] code_a;
  logic [13:0] code_b;
  dsw_mode_t mode_a;
  dsw_mode_t mode_b;
  logic load_a;
  logic abort_a;
  logic load_b;
  logic abort_b;
  int miscompares = 0;
  int samples_checked = 0;
  int loads_b = 0;
  int aborts_b = 0;
  localparam logic [15:0] CV [4] = '{16'hffff, 16'h0001, 16'h8000, 16'h5a3c};
  dsw_if lk ();
  dsw_if lb ();
  ////////////////////////////////
  dsw_host #(.CODE_W(16)) u_dsw_host (.mclk(mclk), .srst(srst), .clk_en(run_en),
    .start(start), .code_in(code_in), .mode_in(mode_in), .busy(busy), .link(lk.host));
  dsw_device #(.CODE_W(16)) u_dsw_device (.mclk(mclk), .srst(srst), .clk_en(run_en),
    .link(lk.device), .dac_code(code_a), .pwr_mode(mode_a), .load_pulse(load_a),
    .abort_pulse(abort_a));
  dsw_device #(.CODE_W(14)) u_dsw_device_b (.mclk(mclk), .srst(srst), .clk_en(run_en),
    .link(lb.device), .dac_code(code_b), .pwr_mode(mode_b), .load_pulse(load_b),
    .abort_pulse(abort_b));
  dsw_link_asserts u_dsw_link_asserts (.mclk(mclk), .srst(srst),
    .frame_select_n(lk.frame_select_n), .serial_clock(lk.serial_clock),
    .serial_data_in(lk.serial_data_in), .dac_code(code_a), .pwr_mode(mode_a),
    .load_pulse(load_a), .abort_pulse(abort_a));
  ////////////////////////////////
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    loads_b += int'(load_b);
    aborts_b += int'(abort_b);
  end
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic wr(input logic [1:0] m, input logic [15:0] c);
    int n;
    start = 1'b1;
    code_in = c;
    mode_in = dsw_mode_t'(m);
    @(posedge mclk) #1;
    start = 1'b0;
    for (n = 0; n < 600 && !load_a; n++) @(posedge mclk) #1;
    `CHK(code_a, c)
    `CHK(mode_a, dsw_mode_t'(m))
    for (n = 0; n < 600 && busy; n++) @(posedge mclk) #1;
    `CHK(busy, 1'b0)
  endtask : wr
  // Bench-made link clock, 125 ns, still outside frames; data set on the rise
  task automatic bang(input logic [15:0] f, input int n);
    lb.frame_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      #62.5 lb.serial_clock = 1'b1;
      lb.serial_data_in = f[15 - (i % 16)];
      #62.5 lb.serial_clock = 1'b0;
    end
    #62.5 lb.frame_select_n = 1'b1;
    lb.serial_data_in = ~lb.serial_data_in;
    repeat (12) @(posedge mclk);
    #1;
  endtask : bang
  ////////////////////////////////
  initial begin
    lb.frame_select_n = 1'b1;
    lb.serial_clock = 1'b0;
    lb.serial_data_in = 1'b0;
    repeat (20) @(posedge mclk);
    #1 srst = 1'b0;
    repeat (4) @(posedge mclk) #1;
    `CHK(code_a, 16'h0000)
    `CHK(code_b, 14'h0000)
    for (int i = 0; i < 4; i++) wr(2'(i), CV[i]);
    bang({2'b10, 14'h2abc}, 16);
    `CHK(code_b, 14'h2abc)
    `CHK(mode_b, DSW_PD_100K)
    `CHK(loads_b, 1)
    bang({2'b01, 14'h1555}, 15);
    `CHK(code_b, 14'h2abc)
    `CHK(mode_b, DSW_PD_100K)
    `CHK(aborts_b, 1)
    bang({2'b11, 14'h0fff}, 20);
    `CHK(code_b, 14'h0fff)
    `CHK(loads_b, 2)
    `CHK(mode_b, DSW_PD_HIZ)
    run_en = 1'b0;
    bang({2'b00, 14'h0123}, 16);
    `CHK(loads_b, 2)
    `CHK(code_b, 14'h0fff)
    run_en = 1'b1;
    close_out();
  end
  // Whole run is near 2200 cycles; this leaves ample margin
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule : dac_serial_write_interface_tb
